// [core/pebx_field.v]
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------
// Gated event field register
// -----------------------------------------------------------------
module pebx_field #(
    parameter W = 1
) (
    input wire clk,
    input wire rst_n,
    input wire enable,
    input wire [W-1:0] value,
    output reg [W-1:0] field_q
);
    // Zero in reset and whenever export is off or no event occurs
    always @(posedge clk) begin
        if (!rst_n) begin
            field_q <= {W{1'b0}};
        end else if (enable) begin
            field_q <= value;
        end else begin
            field_q <= {W{1'b0}};
        end
    end
endmodule

`default_nettype wire

// [core/pebx_top.v]
`timescale 1ns/1ps
`default_nettype none
`include "pebx_map.vh"

module pebx_top (
    input wire MCLK,
    input wire RESET_N,
    input wire EXPORT_EN,
    input wire [`PEBX_NSGL-1:0] EVT_SINGLE,
    input wire [`PEBX_NCNT*`PEBX_CNT_W-1:0] EVT_COUNT,
    input wire [`PEBX_INSTR_W-1:0] EVT_INSTR_CNT,
    input wire PERF_IRQ_REQ,
    output wire [`PEBX_TRC_W-1:0] PERF_EVENT_BUS_TRC,
    output wire [`PEBX_EXT_W-1:0] PERF_EVENT_BUS_EXT,
    output reg PERF_IRQ_N,
    output reg CROSS_TRIGGER_UNIT_IRQ
);

    // -------------------------------------------------------------
    // Port behaviour
    // -------------------------------------------------------------
    // EVT_SINGLE: one bit per single-occurrence event, high for one
    // cycle per occurrence. Slots 0 to 47 are mapped; slots 48 to 57
    // are spare and never reach either bus.
    // EVT_COUNT: eighteen two-bit binary counts, slot k on bits
    // 2k+1 down to 2k. A count of zero leaves its field at zero.
    // EVT_INSTR_CNT: executed instructions this cycle, binary, and
    // the only multi-bit field that appears on both buses.
    // EXPORT_EN: export control bit, taken as asynchronous. It gates
    // both buses together, so the two never disagree about whether
    // export is on, and it never reaches the interrupt path.
    // PERF_IRQ_REQ: monitor interrupt request, same clock domain.
    //
    // Latency: an input set up before edge N shows on the buses from
    // edge N and holds for one cycle. A change of EXPORT_EN reaches
    // the buses two edges after it is first sampled.
    //
    // Limitation: a two-bit field saturates nothing; a producer that
    // has more than three occurrences in one cycle must split them,
    // since this block only forwards the count it is handed.
    //
    // The external bus is a strict subset of the trace bus except
    // for the barrier bit, which merges two trace bits into one. A
    // consumer of the external bus cannot tell the barriers apart.
    //
    // Every bus bit comes from a register so the consumers see clean
    // levels for a whole cycle; the cost is one cycle of latency.

    // -------------------------------------------------------------
    // Single-event slot order in EVT_SINGLE (index = slot)
    // -------------------------------------------------------------
    // Each slot names the trace bit it lands on; this table is the
    // only place a single-event slot meets a bus position.
    function [6:0] sgl_pos;
        input integer s;
        begin
            case (s)
                0: sgl_pos = `PEBX_T_SWINC;
                1: sgl_pos = `PEBX_T_L1I_REFILL;
                2: sgl_pos = `PEBX_T_ITLB_REFILL;
                3: sgl_pos = `PEBX_T_L1D_REFILL;
                4: sgl_pos = `PEBX_T_EXC_TAKEN;
                5: sgl_pos = `PEBX_T_EXC_RETURN;
                6: sgl_pos = `PEBX_T_CTXID;
                7: sgl_pos = `PEBX_T_BR_MISPRED;
                8: sgl_pos = `PEBX_T_CYCLE;
                9: sgl_pos = `PEBX_T_BR_PRED;
                10: sgl_pos = `PEBX_T_L1I_ACCESS;
                11: sgl_pos = `PEBX_T_L1D_WB;
                12: sgl_pos = `PEBX_T_L2D_REFILL;
                13: sgl_pos = `PEBX_T_L2D_WB;
                14: sgl_pos = `PEBX_T_LOCAL_ERR;
                15: sgl_pos = `PEBX_T_TTB_WRITE;
                16: sgl_pos = `PEBX_T_BUS_CYCLE;
                17: sgl_pos = `PEBX_T_L1D_RD;
                18: sgl_pos = `PEBX_T_L1D_WR;
                19: sgl_pos = `PEBX_T_L1D_RD_REFILL;
                20: sgl_pos = `PEBX_T_L1D_WR_REFILL;
                21: sgl_pos = `PEBX_T_L1D_VICTIM;
                22: sgl_pos = `PEBX_T_L1D_CLEAN;
                23: sgl_pos = `PEBX_T_L1D_INVAL;
                24: sgl_pos = `PEBX_T_DTLB_RD;
                25: sgl_pos = `PEBX_T_DTLB_WR;
                26: sgl_pos = `PEBX_T_L2D_RD;
                27: sgl_pos = `PEBX_T_L2D_WR;
                28: sgl_pos = `PEBX_T_L2D_RD_REFILL;
                29: sgl_pos = `PEBX_T_L2D_WR_REFILL;
                30: sgl_pos = `PEBX_T_L2D_VICTIM;
                31: sgl_pos = `PEBX_T_L2D_CLEAN;
                32: sgl_pos = `PEBX_T_L2D_INVAL;
                33: sgl_pos = `PEBX_T_BUS_RD;
                34: sgl_pos = `PEBX_T_BUS_WR;
                35: sgl_pos = `PEBX_T_MEM_RD;
                36: sgl_pos = `PEBX_T_MEM_WR;
                37: sgl_pos = `PEBX_T_UNAL_RD;
                38: sgl_pos = `PEBX_T_UNAL_WR;
                39: sgl_pos = `PEBX_T_LDEX;
                40: sgl_pos = `PEBX_T_STEX_PASS;
                41: sgl_pos = `PEBX_T_STEX_FAIL;
                42: sgl_pos = `PEBX_T_BR_IMM;
                43: sgl_pos = `PEBX_T_BR_RET;
                44: sgl_pos = `PEBX_T_BR_IND;
                45: sgl_pos = `PEBX_T_ISB;
                46: sgl_pos = `PEBX_T_DSB;
                default: sgl_pos = `PEBX_T_DMB;
            endcase
        end
    endfunction

    // Count slot to trace field low bit
    // The speculative class fields sit back to back, so their low bit
    // is computed rather than listed; the sum is cut to the index width.
    function [6:0] cnt_pos;
        input integer c;
        integer p;
        begin
            p = `PEBX_T_SPEC_CLASS + (c - `PEBX_C_SPEC_CLASS) * `PEBX_CNT_W;
            case (c)
                0: cnt_pos = `PEBX_T_L1D_ACCESS;
                1: cnt_pos = `PEBX_T_DTLB_REFILL;
                2: cnt_pos = `PEBX_T_MEM_ACCESS;
                3: cnt_pos = `PEBX_T_L2D_ACCESS;
                4: cnt_pos = `PEBX_T_BUS_ACCESS;
                5: cnt_pos = `PEBX_T_INSTR_SPEC;
                6: cnt_pos = `PEBX_T_BUS_NORMAL;
                7: cnt_pos = `PEBX_T_BUS_NOTNORM;
                8: cnt_pos = `PEBX_T_BUS_NORMAL2;
                9: cnt_pos = `PEBX_T_BUS_PERIPH;
                10: cnt_pos = `PEBX_T_UNAL;
                default: cnt_pos = p[6:0];
            endcase
        end
    endfunction

    // -------------------------------------------------------------
    // Trace-side next value
    // -------------------------------------------------------------
    // Only 48 single slots are used; slots above 47 are spare inputs
    // that land nowhere, matching reserved event numbers.
    localparam NUSED = 48;
    reg [`PEBX_TRC_W-1:0] trc_d;
    integer i;

    // Slots above 47 are never read, so reserved events drive nothing.
    // Start from zero so no trace bit is left without a value on any
    // path; the single and count tables never overlap, so no later
    // write in this process hides an earlier one.
    always @* begin
        trc_d = `PEBX_TRC_RST;
        for (i = 0; i < NUSED; i = i + 1) begin
            trc_d[sgl_pos(i)] = EVT_SINGLE[i];
        end
        for (i = 0; i < `PEBX_NCNT; i = i + 1) begin
            trc_d[cnt_pos(i) +: `PEBX_CNT_W] =
                EVT_COUNT[i*`PEBX_CNT_W +: `PEBX_CNT_W];
        end
        trc_d[`PEBX_T_INSTR_HI:`PEBX_T_INSTR_LO] = EVT_INSTR_CNT;
    end

    // -------------------------------------------------------------
    // External-side next value
    // -------------------------------------------------------------
    // Built from the trace image, except the instruction count taken from EVT_INSTR_CNT, so both buses always agree.
    // Trace-only events are simply not copied here, which keeps the
    // external bus narrow for pins outside the chip.
    reg [`PEBX_EXT_W-1:0] ext_d;
    always @* begin
        ext_d = `PEBX_EXT_RST;
        ext_d[`PEBX_X_L1I_REFILL] = trc_d[`PEBX_T_L1I_REFILL];
        ext_d[`PEBX_X_ITLB_REFILL] = trc_d[`PEBX_T_ITLB_REFILL];
        ext_d[`PEBX_X_L1D_REFILL] = trc_d[`PEBX_T_L1D_REFILL];
        ext_d[`PEBX_X_INSTR_HI:`PEBX_X_INSTR_LO] = EVT_INSTR_CNT;
        ext_d[`PEBX_X_EXC_TAKEN] = trc_d[`PEBX_T_EXC_TAKEN];
        ext_d[`PEBX_X_EXC_RETURN] = trc_d[`PEBX_T_EXC_RETURN];
        ext_d[`PEBX_X_BR_MISPRED] = trc_d[`PEBX_T_BR_MISPRED];
        ext_d[`PEBX_X_BR_PRED] = trc_d[`PEBX_T_BR_PRED];
        ext_d[`PEBX_X_L1I_ACCESS] = trc_d[`PEBX_T_L1I_ACCESS];
        ext_d[`PEBX_X_L1D_WB] = trc_d[`PEBX_T_L1D_WB];
        ext_d[`PEBX_X_L2D_REFILL] = trc_d[`PEBX_T_L2D_REFILL];
        ext_d[`PEBX_X_L2D_WB] = trc_d[`PEBX_T_L2D_WB];
        ext_d[`PEBX_X_L1D_RD] = trc_d[`PEBX_T_L1D_RD];
        ext_d[`PEBX_X_L1D_WR] = trc_d[`PEBX_T_L1D_WR];
        ext_d[`PEBX_X_DTLB_RD] = trc_d[`PEBX_T_DTLB_RD];
        ext_d[`PEBX_X_DTLB_WR] = trc_d[`PEBX_T_DTLB_WR];
        ext_d[`PEBX_X_L2D_RD] = trc_d[`PEBX_T_L2D_RD];
        ext_d[`PEBX_X_L2D_WR] = trc_d[`PEBX_T_L2D_WR];
        ext_d[`PEBX_X_LDEX] = trc_d[`PEBX_T_LDEX];
        ext_d[`PEBX_X_STEX_PASS] = trc_d[`PEBX_T_STEX_PASS];
        ext_d[`PEBX_X_STEX_FAIL] = trc_d[`PEBX_T_STEX_FAIL];
        // Barriers merge: software cannot tell them apart here
        ext_d[`PEBX_X_BARRIER] = trc_d[`PEBX_T_DSB] |
            trc_d[`PEBX_T_DMB];
    end

    // -------------------------------------------------------------
    // Export enable synchroniser
    // -------------------------------------------------------------
    // The enable comes from the control register of another block,
    // treated as asynchronous; events lag its change by two cycles.
    reg exp_meta_q;
    reg exp_en_q;
    always @(posedge MCLK) begin
        if (!RESET_N) begin
            exp_meta_q <= 1'b0;
            exp_en_q <= 1'b0;
        end else begin
            exp_meta_q <= EXPORT_EN;
            exp_en_q <= exp_meta_q;
        end
    end

    // -------------------------------------------------------------
    // Registered event buses
    // -------------------------------------------------------------
    pebx_field #(
        .W(`PEBX_TRC_W)
    ) u_trc (
        .clk(MCLK),
        .rst_n(RESET_N),
        .enable(exp_en_q),
        .value(trc_d),
        .field_q(PERF_EVENT_BUS_TRC)
    );

    pebx_field #(
        .W(`PEBX_EXT_W)
    ) u_ext (
        .clk(MCLK),
        .rst_n(RESET_N),
        .enable(exp_en_q),
        .value(ext_d),
        .field_q(PERF_EVENT_BUS_EXT)
    );

    // -------------------------------------------------------------
    // Interrupt outputs
    // -------------------------------------------------------------
    // Request is same-domain logic; export enable never gates it.
    // The controller alone routes it back to the core.
    // Both copies come from one request in one register stage, so the
    // cross-trigger copy is always the exact inverse of the interrupt.
    // Reset parks the interrupt high, its inactive level.
    always @(posedge MCLK) begin
        if (!RESET_N) begin
            PERF_IRQ_N <= 1'b1;
            CROSS_TRIGGER_UNIT_IRQ <= 1'b0;
        end else begin
            PERF_IRQ_N <= ~PERF_IRQ_REQ;
            CROSS_TRIGGER_UNIT_IRQ <= PERF_IRQ_REQ;
        end
    end

endmodule

`default_nettype wire

// [include/pebx_map.vh]
`ifndef PEBX_MAP_VH
`define PEBX_MAP_VH

// Bus widths
`define PEBX_TRC_W 88
`define PEBX_EXT_W 25
// Single-occurrence event inputs: 48 map to single-bit trace fields, 10 are spare
`define PEBX_NSGL 58
// Count event inputs, two-bit fields, plus the four-bit instruction count
`define PEBX_NCNT 18
`define PEBX_CNT_W 2
`define PEBX_INSTR_W 4

// Trace-side field positions
`define PEBX_T_SWINC 0
`define PEBX_T_L1I_REFILL 1
`define PEBX_T_ITLB_REFILL 2
`define PEBX_T_L1D_REFILL 3
`define PEBX_T_L1D_ACCESS 4
`define PEBX_T_DTLB_REFILL 6
`define PEBX_T_INSTR_LO 8
`define PEBX_T_INSTR_HI 11
`define PEBX_T_EXC_TAKEN 12
`define PEBX_T_EXC_RETURN 13
`define PEBX_T_CTXID 14
`define PEBX_T_BR_MISPRED 15
`define PEBX_T_CYCLE 16
`define PEBX_T_BR_PRED 17
`define PEBX_T_MEM_ACCESS 18
`define PEBX_T_L1I_ACCESS 20
`define PEBX_T_L1D_WB 21
`define PEBX_T_L2D_ACCESS 22
`define PEBX_T_L2D_REFILL 24
`define PEBX_T_L2D_WB 25
`define PEBX_T_BUS_ACCESS 26
`define PEBX_T_LOCAL_ERR 28
`define PEBX_T_INSTR_SPEC 29
`define PEBX_T_TTB_WRITE 31
`define PEBX_T_BUS_CYCLE 32
`define PEBX_T_L1D_RD 33
`define PEBX_T_L1D_WR 34
`define PEBX_T_L1D_RD_REFILL 35
`define PEBX_T_L1D_WR_REFILL 36
`define PEBX_T_L1D_VICTIM 37
`define PEBX_T_L1D_CLEAN 38
`define PEBX_T_L1D_INVAL 39
`define PEBX_T_DTLB_RD 40
`define PEBX_T_DTLB_WR 41
`define PEBX_T_L2D_RD 42
`define PEBX_T_L2D_WR 43
`define PEBX_T_L2D_RD_REFILL 44
`define PEBX_T_L2D_WR_REFILL 45
`define PEBX_T_L2D_VICTIM 46
`define PEBX_T_L2D_CLEAN 47
`define PEBX_T_L2D_INVAL 48
`define PEBX_T_BUS_RD 49
`define PEBX_T_BUS_WR 50
`define PEBX_T_BUS_NORMAL 51
`define PEBX_T_BUS_NOTNORM 53
`define PEBX_T_BUS_NORMAL2 55
`define PEBX_T_BUS_PERIPH 57
`define PEBX_T_MEM_RD 59
`define PEBX_T_MEM_WR 60
`define PEBX_T_UNAL_RD 61
`define PEBX_T_UNAL_WR 62
`define PEBX_T_UNAL 63
`define PEBX_T_LDEX 65
`define PEBX_T_STEX_PASS 66
`define PEBX_T_STEX_FAIL 67
`define PEBX_T_SPEC_CLASS 68
`define PEBX_T_BR_IMM 82
`define PEBX_T_BR_RET 83
`define PEBX_T_BR_IND 84
`define PEBX_T_ISB 85
`define PEBX_T_DSB 86
`define PEBX_T_DMB 87

// External-side field positions
`define PEBX_X_L1I_REFILL 0
`define PEBX_X_ITLB_REFILL 1
`define PEBX_X_L1D_REFILL 2
`define PEBX_X_INSTR_LO 3
`define PEBX_X_INSTR_HI 6
`define PEBX_X_EXC_TAKEN 7
`define PEBX_X_EXC_RETURN 8
`define PEBX_X_BR_MISPRED 9
`define PEBX_X_BR_PRED 10
`define PEBX_X_L1I_ACCESS 11
`define PEBX_X_L1D_WB 12
`define PEBX_X_L2D_REFILL 13
`define PEBX_X_L2D_WB 14
`define PEBX_X_L1D_RD 15
`define PEBX_X_L1D_WR 16
`define PEBX_X_DTLB_RD 17
`define PEBX_X_DTLB_WR 18
`define PEBX_X_L2D_RD 19
`define PEBX_X_L2D_WR 20
`define PEBX_X_LDEX 21
`define PEBX_X_STEX_PASS 22
`define PEBX_X_STEX_FAIL 23
`define PEBX_X_BARRIER 24

// Count field slots in the count input vector
`define PEBX_C_L1D_ACCESS 0
`define PEBX_C_DTLB_REFILL 1
`define PEBX_C_MEM_ACCESS 2
`define PEBX_C_L2D_ACCESS 3
`define PEBX_C_BUS_ACCESS 4
`define PEBX_C_INSTR_SPEC 5
`define PEBX_C_BUS_NORMAL 6
`define PEBX_C_BUS_NOTNORM 7
`define PEBX_C_BUS_NORMAL2 8
`define PEBX_C_BUS_PERIPH 9
`define PEBX_C_UNAL 10
`define PEBX_C_SPEC_CLASS 11
`define PEBX_NSPEC 7

// Reset values
`define PEBX_TRC_RST 88'h0
`define PEBX_EXT_RST 25'h0
`define PEBX_CNT_ZERO 2'h0

`endif

// [test/pebx_checker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pebx_map.vh"

// ------------------------------------------------------------
// Export checker
// ------------------------------------------------------------
module pebx_checker (
    input wire MCLK,
    input wire RESET_N,
    input wire EXPORT_EN,
    input wire [`PEBX_NSGL-1:0] EVT_SINGLE,
    input wire [`PEBX_NCNT*`PEBX_CNT_W-1:0] EVT_COUNT,
    input wire [`PEBX_INSTR_W-1:0] EVT_INSTR_CNT,
    input wire PERF_IRQ_REQ,
    input wire [`PEBX_TRC_W-1:0] PERF_EVENT_BUS_TRC,
    input wire [`PEBX_EXT_W-1:0] PERF_EVENT_BUS_EXT,
    input wire PERF_IRQ_N,
    input wire CROSS_TRIGGER_UNIT_IRQ
);
    logic [2:0] on_q;
    logic [2:0] off_q;
    wire on_ok;

    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);

    // Run lengths of the export bit; margin covers the synchroniser
    always @(posedge MCLK) begin
        if (!RESET_N || !EXPORT_EN)
            on_q <= 3'h0;
        else if (on_q != 3'h7)
            on_q <= on_q + 3'h1;
    end
    always @(posedge MCLK) begin
        if (!RESET_N || EXPORT_EN)
            off_q <= 3'h0;
        else if (off_q != 3'h7)
            off_q <= off_q + 3'h1;
    end
    assign on_ok = (on_q >= 3'h5);

    property p_irq_set;
        $past(RESET_N) && PERF_IRQ_REQ |=> !PERF_IRQ_N;
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("interrupt not asserted after request");
    property p_irq_clr;
        !PERF_IRQ_REQ |=> PERF_IRQ_N;
    endproperty
    a_irq_clr: assert property (p_irq_clr)
        else $error("interrupt stayed low without request");
    property p_trig;
        CROSS_TRIGGER_UNIT_IRQ == !PERF_IRQ_N;
    endproperty
    a_trig: assert property (p_trig)
        else $error("trigger copy differs from interrupt");
    property p_gate_off;
        off_q >= 3'h4 |=> PERF_EVENT_BUS_TRC == 88'h0
            && PERF_EVENT_BUS_EXT == 25'h0;
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("events exported while disabled");
    property p_swinc;
        on_ok |=> PERF_EVENT_BUS_TRC[0] == $past(EVT_SINGLE[0]);
    endproperty
    a_swinc: assert property (p_swinc)
        else $error("software increment bit wrong");
    property p_instr;
        on_ok |=> PERF_EVENT_BUS_EXT[6:3] == $past(EVT_INSTR_CNT)
            && PERF_EVENT_BUS_TRC[11:8] == $past(EVT_INSTR_CNT);
    endproperty
    a_instr: assert property (p_instr)
        else $error("instruction count field wrong");
    property p_barrier;
        on_ok |=> PERF_EVENT_BUS_EXT[24] ==
            ($past(EVT_SINGLE[46]) | $past(EVT_SINGLE[47]));
    endproperty
    a_barrier: assert property (p_barrier)
        else $error("shared barrier bit wrong");
    property p_excl;
        on_ok |=> PERF_EVENT_BUS_EXT[23:21] == $past(EVT_SINGLE[41:39]);
    endproperty
    a_excl: assert property (p_excl)
        else $error("exclusive events wrong");
    property p_l2;
        on_ok |=> PERF_EVENT_BUS_TRC[23:22] == $past(EVT_COUNT[7:6]);
    endproperty
    a_l2: assert property (p_l2)
        else $error("level 2 access count wrong");
endmodule

bind pebx_top pebx_checker u_chk (.MCLK(MCLK), .RESET_N(RESET_N),
    .EXPORT_EN(EXPORT_EN), .EVT_SINGLE(EVT_SINGLE),
    .EVT_COUNT(EVT_COUNT), .EVT_INSTR_CNT(EVT_INSTR_CNT),
    .PERF_IRQ_REQ(PERF_IRQ_REQ), .PERF_EVENT_BUS_TRC(PERF_EVENT_BUS_TRC),
    .PERF_EVENT_BUS_EXT(PERF_EVENT_BUS_EXT), .PERF_IRQ_N(PERF_IRQ_N),
    .CROSS_TRIGGER_UNIT_IRQ(CROSS_TRIGGER_UNIT_IRQ));

`default_nettype wire

// [test/pebx_far_end.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pebx_map.vh"

// ------------------------------------------------------------
// Interrupt controller seen from the monitor's far side
// ------------------------------------------------------------
module pebx_far_end (
    input wire logic perf_irq_n,
    input wire logic irq_mask,
    output logic core_irq
);
    // Only path back to the core; masking lives here, not in the monitor
    assign core_irq = !perf_irq_n && !irq_mask;
endmodule

`default_nettype wire

// [test/perf_event_bus_export_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pebx_map.vh"

module perf_event_bus_export_tb;
    logic mclk = 1'b0;
    logic rst_n, en, irq_req, irq_mask;
    logic [57:0] single;
    logic [35:0] count;
    logic [3:0] instr;
    wire [87:0] trc;
    wire [24:0] ext;
    wire irq_n, trig, core_irq;
    int fails = 0;
    int n_tests = 0;
    // Trace bit per single slot, external bit (-1 none) and count low bit
    int t_bit [48] = '{0,1,2,3,12,13,14,15,16,17,20,21,24,25,28,31,32,
        33,34,35,36,37,38,39,40,41,42,43,44,45,46,47,48,49,50,59,60,61,
        62,65,66,67,82,83,84,85,86,87};
    int x_bit [48] = '{-1,0,1,2,7,8,-1,9,-1,10,11,12,13,14,-1,-1,-1,15,
        16,-1,-1,-1,-1,-1,17,18,19,20,-1,-1,-1,-1,-1,-1,-1,-1,-1,-1,-1,
        21,22,23,-1,-1,-1,-1,24,24};
    int c_lo [18] = '{4,6,18,22,26,29,51,53,55,57,63,68,70,72,74,76,
        78,80};

    always #10 mclk = ~mclk;

    pebx_top u_dut (.MCLK(mclk), .RESET_N(rst_n), .EXPORT_EN(en),
        .EVT_SINGLE(single), .EVT_COUNT(count), .EVT_INSTR_CNT(instr),
        .PERF_IRQ_REQ(irq_req), .PERF_EVENT_BUS_TRC(trc),
        .PERF_EVENT_BUS_EXT(ext), .PERF_IRQ_N(irq_n),
        .CROSS_TRIGGER_UNIT_IRQ(trig));
    pebx_far_end u_far (.perf_irq_n(irq_n), .irq_mask(irq_mask),
        .core_irq(core_irq));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic step;
        @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string what, input logic [87:0] exp,
        input logic [87:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Events and request held active through reset must not leak out
    task automatic t_reset;
        repeat (3) step();
        chk("reset trace", 88'h0, trc);
        chk("reset ext", 88'h0, 88'(ext));
        chk("reset irq", 88'h1, 88'(irq_n));
        chk("reset trig", 88'h0, 88'(trig));
        rst_n = 1'b1;
        single = '0;
        irq_req = 1'b0;
        repeat (5) step();
        $display("reset test done");
    endtask
    // Back-to-back singles, one slot a cycle, then reserved slots
    task automatic t_single;
        for (int s = 0; s < 48; s++) begin
            single = 58'h1 << s;
            step();
            chk("single trace", 88'h1 << t_bit[s], trc);
            chk("single ext", (x_bit[s] < 0) ? 88'h0 : 88'h1 << x_bit[s],
                88'(ext));
        end
        single = {10'h3ff, 48'h0};
        step();
        chk("reserved trace", 88'h0, trc);
        chk("reserved ext", 88'h0, 88'(ext));
        single = '0;
        $display("single test done");
    endtask
    // Every count field with one value from 1..3 in turn, then the instruction count
    task automatic t_count;
        logic [1:0] v;
        for (int k = 0; k < 18; k++) begin
            v = 2'(k % 3 + 1);
            count = 36'(v) << (2 * k);
            step();
            chk("count trace", 88'(v) << c_lo[k], trc);
            chk("count ext", 88'h0, 88'(ext));
        end
        count = '0;
        for (int i = 0; i < 2; i++) begin
            instr = (i == 0) ? 4'h9 : 4'hf;
            step();
            chk("instr trace", 88'(instr) << 8, trc);
            chk("instr ext", 88'(instr) << 3, 88'(ext));
        end
        instr = 4'h0;
        $display("count test done");
    endtask
    // Export off blocks events but not the interrupt; then all on
    task automatic t_gate;
        en = 1'b0;
        repeat (5) step();
        single = '1;
        count = '1;
        instr = 4'hf;
        irq_req = 1'b1;
        step();
        chk("gated trace", 88'h0, trc);
        chk("gated ext", 88'h0, 88'(ext));
        chk("irq while gated", 88'h0, 88'(irq_n));
        chk("trigger", 88'h1, 88'(trig));
        chk("core irq", 88'h1, 88'(core_irq));
        irq_mask = 1'b1;
        #1;
        chk("masked core irq", 88'h0, 88'(core_irq));
        en = 1'b1;
        repeat (5) step();
        chk("full trace", {88{1'b1}}, trc);
        chk("full ext", 88'h1ffffff, 88'(ext));
        irq_req = 1'b0;
        single = '0;
        count = '0;
        instr = 4'h0;
        step();
        chk("irq release", 88'h1, 88'(irq_n));
        chk("trigger release", 88'h0, 88'(trig));
        chk("idle trace", 88'h0, trc);
        $display("gate test done");
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        $display("[FAIL] run length expected done seen hung");
        print_verdict();
    end

    initial begin
        rst_n = 1'b0;
        en = 1'b1;
        irq_req = 1'b1;
        irq_mask = 1'b0;
        single = '1;
        count = '0;
        instr = 4'h0;
        t_reset();
        t_single();
        t_count();
        t_gate();
        print_verdict();
    end
endmodule

`default_nettype wire
